/* common/port_cfg_pkg.sv */
// ---------------------------------------------------------------------------
// port configuration loader package
// ---------------------------------------------------------------------------
// holds word addresses, field positions, register offsets and types
// assumes 16-bit preset words and a 12-bit wishbone byte address
package port_cfg_pkg;

	localparam int NUM_PORTS = 6;

	// preset memory word addresses
	localparam logic [7:0] PM_FIRST_WADDR   = 8'h50; // port 0 capability word
	localparam logic [7:0] PM_LAST_WADDR    = 8'h5b; // port 5 data word
	localparam logic [7:0] PORT_FIRST_WADDR = 8'h60; // port 0 port word
	localparam logic [7:0] PORT_LAST_WADDR  = 8'h6a; // port 5 port word
	localparam logic [7:0] PM_WSTEP         = 8'h01;
	localparam logic [7:0] PORT_WSTEP       = 8'h02;

	// bit positions inside preset words
	localparam int SRC_AUX_LSB  = 1;
	localparam int SRC_PME_LSB  = 6;
	localparam int SRC_DATA_LSB = 8;
	localparam int SRC_NSR_BIT  = 0;
	localparam int SRC_SLOT_BIT = 0;
	localparam int SRC_CLK_BIT  = 1;
	localparam int SRC_DSI_BIT  = 2;
	localparam int SRC_LPRI_BIT = 3;
	localparam int SRC_PNUM_LSB = 4;
	localparam int SRC_TC_LSB   = 9;

	// configuration dword offsets inside one port window
	localparam logic [8:0] OFS_PM_CAP    = 9'h040;
	localparam logic [8:0] OFS_PM_CTL    = 9'h044;
	localparam logic [8:0] OFS_EXP_CAP   = 9'h0c0;
	localparam logic [8:0] OFS_LINK_CAP  = 9'h0cc;
	localparam logic [8:0] OFS_SLOT_STAT = 9'h0d0;
	localparam logic [8:0] OFS_VC_CAP    = 9'h144;
	localparam logic [8:0] OFS_VC_MAP    = 9'h154;

	// bit positions inside configuration dwords
	localparam int DSI_POS  = 21;
	localparam int AUX_POS  = 22;
	localparam int D1_POS   = 25;
	localparam int D2_POS   = 26;
	localparam int PME_POS  = 28;
	localparam int DATA_POS = 24;
	localparam int NSR_POS  = 3;
	localparam int SLOT_POS = 24;
	localparam int PNUM_POS = 24;
	localparam int CLK_POS  = 28;
	localparam int LPRI_POS = 4;
	localparam int TC_POS   = 1;

	// loader control and status words
	localparam logic [11:0] CTRL_ADDR       = 12'hc00;
	localparam logic [11:0] STAT_ADDR       = 12'hc04;
	localparam int          CTRL_RELOAD_BIT = 0;
	localparam int          STAT_DONE_BIT   = 0;

	typedef struct packed {
		logic [2:0] aux;
		logic [1:0] pme;
		logic [7:0] pm_data;
		logic       keep_state;
		logic       slot_impl;
		logic       slot_clk;
		logic       dsi;
		logic       low_priority_vchan_count;
		logic [2:0] port_num;
		logic [6:0] tc_map;
	} port_cfg_s;

	localparam port_cfg_s CFG_RESET = '0; // port_num reset is the port index

	typedef enum logic [0:0] {
		ST_LOAD  = 1'b0,
		ST_READY = 1'b1
	} load_state_e;

endpackage : port_cfg_pkg

/* logic/port_config_word_loader.sv */
// ---------------------------------------------------------------------------
// preset word loader into per-port configuration fields of a six-port switch
// ---------------------------------------------------------------------------
// assumes a preset memory answering one word per req/ack handshake
// assumes a classic wishbone master for configuration reads
//
// Overview of operation
// [RL1] capability word bits 3:1 become the aux current field, 40h bits 24:22
// [RL2] 40h bit 25 reads as constant one, D1 supported
// [RL3] 40h bit 26 reads as constant one, D2 supported
// [RL4] capability word bits 7:6 become PME support, 40h bits 29:28
// [RL5] data word bits 15:8 become read-only data byte, 44h bits 31:24
// [RL6] soft-reset word bit 0 becomes keep-state flag, 44h bit 3
// [RL7] port word bit 1 drives slot clock flag, D0h bit 28
// [RL8] port word bit 2 drives device init flag, 40h bit 21; port 0 at 60h
// [RL9] port word bit 3 drives low priority vc count, 144h bit 4
// [RL10] port word bits 6:4 become logical port number, CCh bits 26:24
// [RL11] port word bits 15:9 become vc0 traffic class map, 154h bits 7:1
// [RL12] port 1 word at 62h bit 0 drives slot implemented, C0h bit 24
// [RL13] port words continue every two addresses: 64h, 66h, 68h, 6Ah
// [RL14] all words load before host accesses are answered; unloaded fields keep defaults
// [RL15] a word updates only its own port, other ports unchanged; an odd data word also sets the keep-state flag of the next port
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module port_config_word_loader (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [11:0]             adr_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic [31:0]             dat_i,
	output logic                         ack_o,
	output logic [31:0]                  dat_o,
	output logic                         mem_req_o,
	output logic [7:0]                   mem_addr_o,
	input  wire logic                    mem_ack_i,
	input  wire logic [15:0]             mem_data_i,
	output logic                         load_done_o,
	output port_cfg_pkg::port_cfg_s      port_cfg_o [port_cfg_pkg::NUM_PORTS]
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	port_cfg_pkg::load_state_e state_q, state_d;
	logic [7:0]                addr_q, addr_d;
	logic                      req_q, req_d;
	logic                      done_q, done_d;
	logic                      ack_q, ack_d;
	logic [31:0]               dat_q, dat_d;
	port_cfg_pkg::port_cfg_s   cfg_q [port_cfg_pkg::NUM_PORTS];
	port_cfg_pkg::port_cfg_s   cfg_d [port_cfg_pkg::NUM_PORTS];

	logic       take;
	logic       is_pm;
	logic [7:0] pm_rel;
	logic [7:0] pw_rel;
	logic [2:0] pm_port;
	logic [2:0] pw_port;
	logic       pm_odd;
	logic       accept;
	logic       reload_wr;

	// ------------------------------------------------------------------
	// preset word decode
	// ------------------------------------------------------------------
	// word handed over by memory this cycle
	assign take    = req_q && mem_ack_i;
	assign is_pm   = addr_q < port_cfg_pkg::PORT_FIRST_WADDR;
	assign pm_rel  = addr_q - port_cfg_pkg::PM_FIRST_WADDR;
	assign pw_rel  = addr_q - port_cfg_pkg::PORT_FIRST_WADDR;
	assign pm_port = pm_rel[3:1]; // two words per port
	assign pm_odd  = pm_rel[0];   // odd word: data byte plus next port soft reset
	assign pw_port = pw_rel[3:1];

	// ------------------------------------------------------------------
	// per-port field update
	// ------------------------------------------------------------------
	for (genvar g = 0; g < port_cfg_pkg::NUM_PORTS; g++) begin : g_port
		// only the addressed port takes the word; the next port takes the soft-reset bit of an odd word
		always_comb begin
			cfg_d[g] = cfg_q[g]; // RL15
			if (take && is_pm && !pm_odd && pm_port == 3'(g)) begin
				cfg_d[g].aux = mem_data_i[port_cfg_pkg::SRC_AUX_LSB +: 3]; // RL1
				cfg_d[g].pme = mem_data_i[port_cfg_pkg::SRC_PME_LSB +: 2]; // RL4
			end
			if (take && is_pm && pm_odd && pm_port == 3'(g)) begin
				cfg_d[g].pm_data = mem_data_i[port_cfg_pkg::SRC_DATA_LSB +: 8]; // RL5
			end
			if (take && is_pm && pm_odd && ({1'b0, pm_port} + 4'h1) == 4'(g)) begin
				cfg_d[g].keep_state = mem_data_i[port_cfg_pkg::SRC_NSR_BIT]; // RL6
			end
			if (take && !is_pm && pw_port == 3'(g)) begin
				if (g != 0) begin
					cfg_d[g].slot_impl = mem_data_i[port_cfg_pkg::SRC_SLOT_BIT]; // RL12
				end
				cfg_d[g].slot_clk                 = mem_data_i[port_cfg_pkg::SRC_CLK_BIT];     // RL7
				cfg_d[g].dsi                      = mem_data_i[port_cfg_pkg::SRC_DSI_BIT];     // RL8
				cfg_d[g].low_priority_vchan_count = mem_data_i[port_cfg_pkg::SRC_LPRI_BIT];    // RL9
				cfg_d[g].port_num                 = mem_data_i[port_cfg_pkg::SRC_PNUM_LSB +: 3]; // RL10
				cfg_d[g].tc_map                   = mem_data_i[port_cfg_pkg::SRC_TC_LSB +: 7];   // RL11
			end
		end

		// field registers, defaults until a word arrives
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cfg_q[g]          <= port_cfg_pkg::CFG_RESET; // RL14
				cfg_q[g].port_num <= 3'(g);
			end else begin
				cfg_q[g] <= cfg_d[g];
			end
		end

		assign port_cfg_o[g] = cfg_q[g];
	end

	// ------------------------------------------------------------------
	// load sequencer
	// ------------------------------------------------------------------
	// walks 50h..5Bh one by one, then 60h..6Ah in steps of two
	always_comb begin
		state_d = state_q;
		addr_d  = addr_q;
		req_d   = req_q;
		done_d  = done_q;
		unique case (state_q)
			port_cfg_pkg::ST_LOAD: begin
				req_d = 1'b1;
				if (take) begin
					req_d = 1'b0; // one idle cycle between words
					if (addr_q == port_cfg_pkg::PORT_LAST_WADDR) begin
						state_d = port_cfg_pkg::ST_READY;
						done_d  = 1'b1;
					end else if (addr_q == port_cfg_pkg::PM_LAST_WADDR) begin
						addr_d = port_cfg_pkg::PORT_FIRST_WADDR;
					end else if (is_pm) begin
						addr_d = addr_q + port_cfg_pkg::PM_WSTEP;
					end else begin
						addr_d = addr_q + port_cfg_pkg::PORT_WSTEP; // RL13
					end
				end
			end
			port_cfg_pkg::ST_READY: begin
				if (reload_wr) begin
					state_d = port_cfg_pkg::ST_LOAD;
					done_d  = 1'b0;
					addr_d  = port_cfg_pkg::PM_FIRST_WADDR;
				end
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= port_cfg_pkg::ST_LOAD;
			addr_q  <= port_cfg_pkg::PM_FIRST_WADDR;
			req_q   <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q  <= addr_d;
			req_q   <= req_d;
			done_q  <= done_d;
		end
	end

	assign mem_req_o   = req_q;
	assign mem_addr_o  = addr_q;
	assign load_done_o = done_q;

	// ------------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------------
	// requests wait, unanswered, until loading has finished
	assign accept    = cyc_i && stb_i && !ack_q && state_q == port_cfg_pkg::ST_READY; // RL14
	assign reload_wr = accept && we_i && adr_i == port_cfg_pkg::CTRL_ADDR && sel_i[0]
	                   && dat_i[port_cfg_pkg::CTRL_RELOAD_BIT];

	// answer and read data
	always_comb begin
		port_cfg_pkg::port_cfg_s pc;
		logic [31:0]             rd;
		pc = port_cfg_pkg::CFG_RESET;
		rd = 32'h0000_0000;
		for (int i = 0; i < port_cfg_pkg::NUM_PORTS; i++) begin
			if (adr_i[11:9] == 3'(i)) begin
				pc = cfg_q[i];
			end
		end
		if (adr_i == port_cfg_pkg::STAT_ADDR) begin
			rd[port_cfg_pkg::STAT_DONE_BIT] = done_q;
		end else if (adr_i[11:9] < 3'(port_cfg_pkg::NUM_PORTS)) begin
			case (adr_i[8:0])
				port_cfg_pkg::OFS_PM_CAP: begin
					rd[port_cfg_pkg::DSI_POS]       = pc.dsi;  // RL8
					rd[port_cfg_pkg::AUX_POS +: 3]  = pc.aux;  // RL1
					rd[port_cfg_pkg::D1_POS]        = 1'b1;    // RL2
					rd[port_cfg_pkg::D2_POS]        = 1'b1;    // RL3
					rd[port_cfg_pkg::PME_POS +: 2]  = pc.pme;  // RL4
				end
				port_cfg_pkg::OFS_PM_CTL: begin
					rd[port_cfg_pkg::DATA_POS +: 8] = pc.pm_data;    // RL5
					rd[port_cfg_pkg::NSR_POS]       = pc.keep_state; // RL6
				end
				port_cfg_pkg::OFS_EXP_CAP:   rd[port_cfg_pkg::SLOT_POS]      = pc.slot_impl;                // RL12
				port_cfg_pkg::OFS_LINK_CAP:  rd[port_cfg_pkg::PNUM_POS +: 3] = pc.port_num;                 // RL10
				port_cfg_pkg::OFS_SLOT_STAT: rd[port_cfg_pkg::CLK_POS]       = pc.slot_clk;                 // RL7
				port_cfg_pkg::OFS_VC_CAP:    rd[port_cfg_pkg::LPRI_POS]      = pc.low_priority_vchan_count; // RL9
				port_cfg_pkg::OFS_VC_MAP:    rd[port_cfg_pkg::TC_POS +: 7]   = pc.tc_map;                   // RL11
				default:                     rd = 32'h0000_0000; // unmapped reads zero
			endcase
		end
		ack_d = accept;
		dat_d = (accept && !we_i) ? rd : 32'h0000_0000;
	end

	// bus answer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	chk_aux_load: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
		take && addr_q == 8'h50 |=> cfg_q[0].aux == $past(mem_data_i[3:1]))
		else $error("aux current not loaded");

	chk_d1_const: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
		accept && !we_i && adr_i == 12'h240 |=> ack_q && dat_q[25])
		else $error("d1 support bit not one");

	chk_d2_const: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
		accept && !we_i && adr_i == 12'ha40 |=> ack_q && dat_q[26])
		else $error("d2 support bit not one");

	chk_pme_load: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
		take && addr_q == 8'h5a |=> cfg_q[5].pme == $past(mem_data_i[7:6]))
		else $error("pme support not loaded");

	chk_data_load: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
		take && addr_q == 8'h59 |=> cfg_q[4].pm_data == $past(mem_data_i[15:8]))
		else $error("pm data byte not loaded");

	chk_keep_state: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
		take && addr_q == 8'h59 |=> cfg_q[5].keep_state == $past(mem_data_i[0]) && $stable(cfg_q[4].keep_state))
		else $error("keep state flag misplaced");

	chk_port0_word: assert property (@(posedge clk_i) disable iff (rst_i) // RL7 RL8 RL9 RL10 RL11
		take && addr_q == 8'h60 |=> cfg_q[0].slot_clk == $past(mem_data_i[1]) && cfg_q[0].dsi == $past(mem_data_i[2])
			&& cfg_q[0].low_priority_vchan_count == $past(mem_data_i[3])
			&& cfg_q[0].port_num == $past(mem_data_i[6:4]) && cfg_q[0].tc_map == $past(mem_data_i[15:9]))
		else $error("port 0 word not applied");

	chk_slot_impl: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
		take && addr_q == 8'h62 |=> cfg_q[1].slot_impl == $past(mem_data_i[0]) && cfg_q[0].slot_impl == 1'b0)
		else $error("slot implemented misplaced");

	chk_addr_step: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
		take && addr_q == 8'h64 |=> !mem_req_o && mem_addr_o == 8'h66 ##1 mem_req_o)
		else $error("port word address step wrong");

	chk_ack_ready: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
		ack_o |-> $past(load_done_o) && !mem_req_o)
		else $error("answer before load done");

	chk_other_port: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
		take && addr_q == 8'h60 |=> $stable(cfg_q[1]) && $stable(cfg_q[5]))
		else $error("word touched another port");

	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
		ack_o |=> !ack_o && dat_o == 32'h0000_0000)
		else $error("bus answer longer than one cycle");

	chk_req_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("preset request dropped early");

	chk_first_data: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
		take && addr_q == 8'h51 |=> cfg_q[0].pm_data == $past(mem_data_i[15:8])
			&& cfg_q[1].keep_state == $past(mem_data_i[0]))
		else $error("first data word misplaced");

	chk_last_word: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
		take && addr_q == 8'h6a |=> cfg_q[5].tc_map == $past(mem_data_i[15:9])
			&& cfg_q[5].slot_impl == $past(mem_data_i[0]))
		else $error("last port word not applied");

	chk_done_last: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
		take && addr_q == 8'h6a |=> load_done_o && !mem_req_o)
		else $error("load not done after last word");

	chk_port0_default: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
		cfg_q[0].slot_impl == 1'b0 && cfg_q[0].keep_state == 1'b0)
		else $error("port 0 unloaded field changed");

endmodule : port_config_word_loader

/* test/preset_mem_model.sv */
// preset word memory model for the loader bench
// assumes one word per req/ack handshake, answer after delay_i idle cycles
`timescale 1ns/1ps
module preset_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [3:0]  delay_i,
	input  wire logic [15:0] salt_i,
	output logic             ack_o,
	output logic [15:0]      data_o
);
	logic [3:0] wait_q;

	// preset content, distinct per address, altered by salt
	function automatic logic [15:0] word_at(input logic [7:0] a, input logic [15:0] s);
		return {a, ~a} ^ s;
	endfunction : word_at

	// one-cycle ack with data; data toggles while req is low or after an ack, holds while waiting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o  <= 1'b0;
			wait_q <= 4'h0;
			data_o <= 16'hffff;
		end else if (ack_o || !req_i) begin
			ack_o  <= 1'b0;
			wait_q <= 4'h0;
			data_o <= ~data_o; // no stale word on the bus
		end else if (wait_q >= delay_i) begin
			ack_o  <= 1'b1;
			data_o <= word_at(addr_i, salt_i);
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule : preset_mem_model

/* test/tb.sv */
// self-checking bench for the port configuration word loader
// assumes the preset memory model and wishbone reads of the config windows
`timescale 1ns/1ps
`define CHECK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
	$display("[ERR] %s exp %h got %h", name, exp, got); end end
module tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [11:0] adr_i = 12'h000;
	logic [3:0]  sel_i = 4'h0, delay = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic        ack_o, mem_req_o, mem_ack_i, load_done_o, rd_done;
	logic [7:0]  mem_addr_o;
	logic [15:0] mem_data_i, salt = 16'h0000;
	int          errors = 0, n_tests = 0, seq_idx = 0;
	port_cfg_pkg::port_cfg_s port_cfg_o [port_cfg_pkg::NUM_PORTS];

	always #4 clk_i = ~clk_i;

	port_config_word_loader uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o), .mem_req_o(mem_req_o),
		.mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
		.load_done_o(load_done_o), .port_cfg_o(port_cfg_o));
	preset_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o), .addr_i(mem_addr_o),
		.delay_i(delay), .salt_i(salt), .ack_o(mem_ack_i), .data_o(mem_data_i));

	// ---------------------------------------------------------------------
	// word address order on the preset link
	// ---------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (!rst_i && mem_req_o && mem_ack_i) begin
			if (mem_addr_o == 8'h50) seq_idx = 0;
			`CHECK("word addr", (seq_idx < 12) ? 8'h50 + 8'(seq_idx) : 8'h60 + 8'(2 * (seq_idx - 12)), mem_addr_o)
			seq_idx++;
		end
	end

	// ---------------------------------------------------------------------
	// bus cycles and expectations
	// ---------------------------------------------------------------------
	task automatic wb_cycle(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= wr;
		adr_i <= a;
		sel_i <= 4'hf;
		dat_i <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 3000);
		rd      = dat_o;
		rd_done = load_done_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		if (n >= 3000) `CHECK("wb ack", 1'b1, ack_o)
	endtask : wb_cycle

	function automatic logic [31:0] exp_reg(input int p, input logic [8:0] ofs);
		logic [15:0] cap, dat, prv, pw;
		logic [31:0] e;
		cap = mem.word_at(8'h50 + 8'(2 * p), salt);
		dat = mem.word_at(8'h51 + 8'(2 * p), salt);
		prv = mem.word_at(8'h4f + 8'(2 * p), salt);
		pw  = mem.word_at(8'h60 + 8'(2 * p), salt);
		e   = 32'h0;
		case (ofs)
			9'h040: begin
				e[29:28] = cap[7:6];
				e[26:25] = 2'b11;
				e[24:22] = cap[3:1];
				e[21]    = pw[2];
			end
			9'h044: begin
				e[31:24] = dat[15:8];
				e[3]     = (p != 0) & prv[0];
			end
			9'h0c0: e[24]    = (p != 0) & pw[0];
			9'h0cc: e[26:24] = pw[6:4];
			9'h0d0: e[28]    = pw[1];
			9'h144: e[4]     = pw[3];
			9'h154: e[7:1]   = pw[15:9];
			default: ;
		endcase
		return e;
	endfunction : exp_reg

	task automatic chk_reg(input int p, input logic [8:0] ofs);
		wb_cycle(1'b0, {3'(p), ofs}, 32'h0);
		`CHECK($sformatf("port %0d ofs %h", p, ofs), exp_reg(p, ofs), rd)
	endtask : chk_reg

	// ---------------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------------
	task automatic check_ports;
		for (int p = 0; p < 6; p++) begin
			chk_reg(p, 9'h040);
			chk_reg(p, 9'h044);
			chk_reg(p, 9'h0c0);
			chk_reg(p, 9'h0cc);
			chk_reg(p, 9'h0d0);
			chk_reg(p, 9'h144);
			chk_reg(p, 9'h154);
			`CHECK("port_num field", exp_reg(p, 9'h0cc) >> 24, 32'(port_cfg_o[p].port_num))
		end
	endtask : check_ports

	task automatic t_serve_after_load;
		wb_cycle(1'b0, port_cfg_pkg::STAT_ADDR, 32'h0);
		`CHECK("done at first ack", 1'b1, rd_done)
		`CHECK("status done", 32'h1, rd)
	endtask : t_serve_after_load

	task automatic t_read_only;
		wb_cycle(1'b1, {3'd2, 9'h040}, 32'hffffffff);
		wb_cycle(1'b1, {3'd4, 9'h044}, 32'hffffffff);
		chk_reg(2, 9'h040);
		chk_reg(4, 9'h044);
		wb_cycle(1'b0, {3'd1, 9'h008}, 32'h0);
		`CHECK("unmapped read", 32'h0, rd)
	endtask : t_read_only

	task automatic t_reload_slow;
		int n;
		salt  <= 16'h5a3c;
		delay <= 4'h3;
		wb_cycle(1'b1, port_cfg_pkg::CTRL_ADDR, 32'h1);
		n = 0;
		while (load_done_o !== 1'b0 && n < 8) begin
			@(posedge clk_i);
			n++;
		end
		`CHECK("reload starts", 1'b0, load_done_o)
		check_ports();
		`CHECK("word count", 18, seq_idx)
	endtask : t_reload_slow

	task automatic complete_run;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// reset, then scenarios in order
	initial begin
		repeat (16) @(posedge clk_i);
		`CHECK("reset word addr", 8'h50, mem_addr_o)
		`CHECK("reset done", 1'b0, load_done_o)
		`CHECK("reset port_num", 3'd3, port_cfg_o[3].port_num)
		rst_i <= 1'b0;
		t_serve_after_load();
		check_ports();
		t_read_only();
		t_reload_slow();
		complete_run();
	end

	// watchdog against a stalled handshake
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		complete_run();
	end
endmodule : tb
